//--- core/bdi_pkg.sv
package bdi_pkg;

    // upper address field that selects a segment
    localparam int SEG_MSB = 31;
    localparam int SEG_LSB = 20;
    localparam int SEG_W = 12;
    // low address bits left for the addressed device
    localparam int DEV_W = 20;

    // standard map, upper twelve bits
    localparam logic [11:0] STD_DRAM_MASK = 12'h3FC;
    localparam logic [11:0] STD_DRAM_BASE = 12'h000;
    localparam logic [11:0] STD_PAR_BASE = 12'h006;
    localparam logic [11:0] STD_TIMER_BASE = 12'h1F8;
    localparam logic [11:0] STD_USER_BASE = 12'h1FA;
    localparam logic [11:0] STD_EPROM_BASE = 12'h1FC;
    localparam logic [11:0] STD_EPROM_MASK = 12'hFFE;
    localparam logic [11:0] STD_SERIAL_BASE = 12'h1FE;

    // emulation map, upper twelve bits
    // emulation dram ignores the top two address bits as well, so it aliases per quarter
    localparam logic [11:0] EMU_DRAM_MASK = 12'h3FC;
    localparam logic [11:0] EMU_DRAM_BASE = 12'h000;
    localparam logic [11:0] EMU_USER_BASE = 12'h004;
    localparam logic [11:0] EMU_USER_MASK = 12'hFFE;
    localparam logic [11:0] EMU_PAR_BASE = 12'h006;
    localparam logic [11:0] EMU_UNUSED_BASE = 12'h008;
    localparam logic [11:0] EMU_ENGINE_BASE = 12'h009;
    localparam logic [11:0] EMU_SERIAL_BASE = 12'h00A;
    localparam logic [11:0] EMU_EPROM_BASE = 12'h1FC;
    localparam logic [11:0] EMU_EPROM_MASK = 12'hFFE;

    // processor interrupt inputs and retimed sources
    localparam int IRQ_N = 6;
    localparam int SRC_N = 4;
    localparam int ROUTE_W = 3;
    localparam int ENDIAN_IRQ = 0;
    localparam logic ENDIAN_BIG = 1'b1;
    localparam logic ENDIAN_LITTLE = 1'b0;

    // default routes: counters to inputs 0 and 1, fifo full to 3, serial to 5
    localparam logic [2:0] ROUTE_DEF0 = 3'h0;
    localparam logic [2:0] ROUTE_DEF1 = 3'h1;
    localparam logic [2:0] ROUTE_DEF2 = 3'h3;
    localparam logic [2:0] ROUTE_DEF3 = 3'h5;

    localparam logic [5:0] IRQ_RESET = 6'h00;

endpackage

//--- core/bdi_sync.sv
`timescale 1ns/1ps
module bdi_sync #(
    parameter int W = 1,
    parameter bit RST_EN = 1'b1
) (
    input wire logic clk, // system clock
    input wire logic rst, // synchronous reset, high
    input wire logic [W-1:0] din, // asynchronous level in
    output logic [W-1:0] dout // retimed level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;

    // the first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst && RST_EN) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end

    assign dout = s2_q;
endmodule // bdi_sync

//--- core/bdi_top.sv
// Summary of operation
// - strap high during reset means big-endian, low means little-endian
// - segment choice looks only at the twelve top address bits
// - maps give up to 4MB of DRAM and 2MB of EPROM
// - device-decoded low address bits pass through untouched
// - four sources are retimed and each routes to any interrupt input
// - default route: counters to inputs 0,1; fifo full 3; serial 5
// - outside emulation, both counter outputs reach the processor as synchronous interrupts
// - emulation: timer inputs carry serial timer, then video fifo empty
// - emulation: serial general-purpose output acts as the timer interrupt
`timescale 1ns/1ps
module bdi_top (
    input wire logic clk, // 40 MHz system clock
    input wire logic rst, // synchronous reset, high
    input wire logic [31:0] addr, // processor address, same clock
    input wire logic addr_valid, // address phase valid, same clock
    input wire logic byte_order_strap, // pin: 1 big, 0 little endian
    input wire logic emulation_mode, // pin: emulation map and sources
    input wire logic route_custom, // pin: use route jumpers, else defaults
    input wire logic [2:0] route_sel0, // pin: target input of source 0
    input wire logic [2:0] route_sel1, // pin: target input of source 1
    input wire logic [2:0] route_sel2, // pin: target input of source 2
    input wire logic [2:0] route_sel3, // pin: target input of source 3
    input wire logic counter_zero_output, // pin: counter 0 output
    input wire logic counter_one_output, // pin: counter 1 output
    input wire logic parallel_fifo_full_irq, // pin: parallel fifo full
    input wire logic serial_ctrl_irq, // pin: serial controller interrupt
    input wire logic serial_gp_output_timer, // pin: serial gp output timer
    input wire logic video_fifo_empty, // pin: video fifo empty
    output logic [5:0] irq_input, // processor interrupt inputs, high
    output logic dram_sel, // dram segment select
    output logic parallel_sel, // parallel port segment select
    output logic timer_sel, // counter/timer segment select
    output logic eprom_sel, // eprom segment select
    output logic serial_sel, // serial controller segment select
    output logic user_sel, // user segment select
    output logic [19:0] dev_addr // low address bits for the device
);
    logic [13:0] cfg_s;
    logic [5:0] raw_s;
    logic strap_s;
    logic custom_s;
    logic emu_s;
    logic [2:0] route_s [bdi_pkg::SRC_N];
    logic [2:0] route_use [bdi_pkg::SRC_N];
    logic [bdi_pkg::SRC_N-1:0] src_s;
    logic [11:0] seg;
    logic [5:0] irq_d;
    logic [5:0] irq_q;
    logic [5:0] sel_d;
    logic [5:0] sel_q;
    logic [19:0] dev_d;
    logic [19:0] dev_q;

    // jumper and mode pins are static, but still retimed so the decode never sees a glitch
    bdi_sync #(.W(14), .RST_EN(1'b1)) u_cfg_sync (
        .clk(clk),
        .rst(rst),
        .din({emulation_mode, route_custom, route_sel3, route_sel2, route_sel1, route_sel0}),
        .dout(cfg_s)
    );

    bdi_sync #(.W(6), .RST_EN(1'b1)) u_src_sync (
        .clk(clk),
        .rst(rst),
        .din({video_fifo_empty, serial_gp_output_timer, serial_ctrl_irq,
              parallel_fifo_full_irq, counter_one_output, counter_zero_output}),
        .dout(raw_s)
    );

    // the strap chain must keep running through reset, so it is never cleared
    bdi_sync #(.W(1), .RST_EN(1'b0)) u_strap_sync (
        .clk(clk),
        .rst(rst),
        .din(byte_order_strap),
        .dout(strap_s)
    );

    assign route_s[0] = cfg_s[2:0];
    assign route_s[1] = cfg_s[5:3];
    assign route_s[2] = cfg_s[8:6];
    assign route_s[3] = cfg_s[11:9];
    assign custom_s = cfg_s[12];
    assign emu_s = cfg_s[13];

    // source selection and routing
    always_comb begin
        src_s[0] = emu_s ? raw_s[4] : raw_s[0];
        src_s[1] = emu_s ? raw_s[5] : raw_s[1];
        src_s[2] = raw_s[2];
        src_s[3] = raw_s[3];
        route_use[0] = custom_s ? route_s[0] : bdi_pkg::ROUTE_DEF0;
        route_use[1] = custom_s ? route_s[1] : bdi_pkg::ROUTE_DEF1;
        route_use[2] = custom_s ? route_s[2] : bdi_pkg::ROUTE_DEF2;
        route_use[3] = custom_s ? route_s[3] : bdi_pkg::ROUTE_DEF3;
        irq_d = bdi_pkg::IRQ_RESET;
        // two sources on one input are ored; a route code of 6 or 7 drops the source
        for (int j = 0; j < bdi_pkg::SRC_N; j++) begin
            for (int k = 0; k < bdi_pkg::IRQ_N; k++) begin
                if (route_use[j] == 3'(k)) begin
                    irq_d[k] = irq_d[k] | src_s[j];
                end
            end
        end
        if (rst) begin
            irq_d = bdi_pkg::IRQ_RESET;
            irq_d[bdi_pkg::ENDIAN_IRQ] = strap_s;
        end
    end

    always_ff @(posedge clk) begin
        irq_q <= irq_d;
    end

    // address decode
    always_comb begin
        seg = addr[bdi_pkg::SEG_MSB:bdi_pkg::SEG_LSB];
        sel_d = 6'h00;
        dev_d = addr[bdi_pkg::DEV_W-1:0];
        if (emu_s) begin
            // timer segment is gone: the counter device is powered down here
            sel_d[0] = (seg & bdi_pkg::EMU_DRAM_MASK) == bdi_pkg::EMU_DRAM_BASE;
            sel_d[1] = seg == bdi_pkg::EMU_PAR_BASE;
            sel_d[3] = (seg & bdi_pkg::EMU_EPROM_MASK) == bdi_pkg::EMU_EPROM_BASE;
            sel_d[4] = seg == bdi_pkg::EMU_SERIAL_BASE;
            sel_d[5] = ((seg & bdi_pkg::EMU_USER_MASK) == bdi_pkg::EMU_USER_BASE)
                     || seg == bdi_pkg::EMU_UNUSED_BASE
                     || seg == bdi_pkg::EMU_ENGINE_BASE;
        end else begin
            // top two bits are ignored for dram, so it aliases in every quarter
            sel_d[0] = (seg & bdi_pkg::STD_DRAM_MASK) == bdi_pkg::STD_DRAM_BASE;
            sel_d[1] = seg == bdi_pkg::STD_PAR_BASE;
            sel_d[2] = seg == bdi_pkg::STD_TIMER_BASE;
            sel_d[3] = (seg & bdi_pkg::STD_EPROM_MASK) == bdi_pkg::STD_EPROM_BASE;
            sel_d[4] = seg == bdi_pkg::STD_SERIAL_BASE;
            sel_d[5] = seg == bdi_pkg::STD_USER_BASE;
        end
        if (!addr_valid || rst) begin
            sel_d = 6'h00;
        end
    end

    always_ff @(posedge clk) begin
        sel_q <= sel_d;
        dev_q <= dev_d;
    end

    assign irq_input = irq_q;
    assign dram_sel = sel_q[0];
    assign parallel_sel = sel_q[1];
    assign timer_sel = sel_q[2];
    assign eprom_sel = sel_q[3];
    assign serial_sel = sel_q[4];
    assign user_sel = sel_q[5];
    assign dev_addr = dev_q;

    // ---------------- assertions ----------------
    sequence s_reset_held;
        rst ##1 rst ##1 rst ##1 rst;
    endsequence

    sequence s_addr_taken;
        addr_valid && !rst;
    endsequence

    property p_strap;
        @(posedge clk) s_reset_held |-> irq_input[0] == $past(byte_order_strap, 3);
    endproperty

    a_endian_strap_pin: assert property (p_strap)
        else $error("strap not shown on interrupt input 0 during reset");

    a_endian_others_low: assert property (@(posedge clk) s_reset_held |->
        irq_input[5:1] == 5'h00)
        else $error("interrupt inputs other than 0 active during reset");

    a_one_hot_sel: assert property (@(posedge clk) disable iff (rst)
        $onehot0({dram_sel, parallel_sel, timer_sel, eprom_sel, serial_sel, user_sel}))
        else $error("more than one segment select");

    a_idle_no_sel: assert property (@(posedge clk) disable iff (rst)
        !addr_valid |=> sel_q == 6'h00)
        else $error("segment select without valid address");

    a_dram_window: assert property (@(posedge clk) disable iff (rst)
        s_addr_taken ##0 (addr[29:22] == 8'h00) |=> dram_sel)
        else $error("dram address not selected");

    a_eprom_window: assert property (@(posedge clk) disable iff (rst)
        s_addr_taken ##0 (addr[31:21] == 11'h0FE) |=> eprom_sel)
        else $error("eprom address not selected");

    a_dev_low_bits: assert property (@(posedge clk) disable iff (rst)
        ##1 dev_addr == $past(addr[19:0]))
        else $error("device low address bits altered");

    a_sync_two_stage: assert property (@(posedge clk) disable iff (rst)
        $rose(raw_s[2]) |-> $past(parallel_fifo_full_irq, 2))
        else $error("source reached logic with fewer than two stages");

    a_default_fifo_route: assert property (@(posedge clk) disable iff (rst)
        ##1 (!$past(custom_s) && !$past(rst)) |-> irq_input[3] == $past(raw_s[2]))
        else $error("fifo full not on interrupt input three");

    a_default_serial_route: assert property (@(posedge clk) disable iff (rst)
        ##1 (!$past(custom_s) && !$past(rst)) |-> irq_input[5] == $past(raw_s[3]))
        else $error("serial interrupt not on interrupt input five");

    a_counter_path: assert property (@(posedge clk) disable iff (rst)
        ##1 (!$past(custom_s) && !$past(emu_s) && !$past(rst))
        |-> irq_input[1:0] == $past(raw_s[1:0]))
        else $error("counter outputs not on inputs zero and one");

    a_emu_timer_path: assert property (@(posedge clk) disable iff (rst)
        ##1 (!$past(custom_s) && $past(emu_s) && !$past(rst))
        |-> irq_input[1:0] == $past(raw_s[5:4]))
        else $error("emulation timer sources misrouted");

    a_custom_route: assert property (@(posedge clk) disable iff (rst)
        ##1 ($past(custom_s) && !$past(rst) && $past(route_s[1]) == 3'h2
        && $past(src_s[1])) |-> irq_input[2])
        else $error("selected route not honoured");

endmodule // bdi_top

//--- tb/bdi_periph_model.sv
`timescale 1ns/1ps
module bdi_periph_model (
    input wire logic clk, // system clock
    input wire logic [5:0] level_req, // wanted source levels, bit 0 = counter 0
    input wire logic strap_req, // wanted byte order
    output logic counter_zero_output, // counter 0 output
    output logic counter_one_output, // counter 1 output
    output logic parallel_fifo_full_irq, // parallel fifo full
    output logic serial_ctrl_irq, // serial controller interrupt
    output logic serial_gp_output_timer, // serial gp output timer
    output logic video_fifo_empty, // video fifo empty
    output logic byte_order_strap // byte order strap pin
);
    // the strap is a board level from power-up, so it never shows an unknown
    logic [5:0] lvl_q = 6'h00;
    logic strap_q = 1'b0;

    // peripherals change their lines off the edge, like real registered outputs
    always @(posedge clk) begin
        lvl_q <= level_req;
        strap_q <= strap_req;
    end

    assign {video_fifo_empty, serial_gp_output_timer, serial_ctrl_irq} = lvl_q[5:3];
    assign {parallel_fifo_full_irq, counter_one_output, counter_zero_output} = lvl_q[2:0];
    assign byte_order_strap = strap_q;
endmodule // bdi_periph_model

//--- tb/bdi_top_tb_top.sv
`timescale 1ns/1ps
module bdi_top_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] addr = 32'h0000_0000;
    logic addr_valid = 1'b0;
    logic emulation_mode = 1'b0;
    logic route_custom = 1'b0;
    logic [2:0] route_sel0 = 3'h4;
    logic [2:0] route_sel1 = 3'h2;
    logic [2:0] route_sel2 = 3'h0;
    logic [2:0] route_sel3 = 3'h7;
    logic [5:0] level_req = 6'h00;
    logic strap_req = 1'b0;
    logic byte_order_strap, counter_zero_output, counter_one_output, parallel_fifo_full_irq;
    logic serial_ctrl_irq, serial_gp_output_timer, video_fifo_empty;
    logic [5:0] irq_input;
    logic dram_sel, parallel_sel, timer_sel, eprom_sel, serial_sel, user_sel;
    logic [19:0] dev_addr;
    logic [5:0] sel;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    // expected select {dram,parallel,timer,eprom,serial,user} above the address
    logic [37:0] std_tbl [12] = '{38'h20_00000000, 38'h20_003FFFFF, 38'h20_C0100004,
        38'h00_00400000, 38'h10_0060ABCD, 38'h08_1F800008, 38'h01_1FA00000,
        38'h04_1FC00010, 38'h04_1FDFFFFF, 38'h02_1FE0000C, 38'h00_1FF00000, 38'h00_20000000};
    logic [37:0] emu_tbl [11] = '{38'h20_003FFFFF, 38'h01_00400000, 38'h01_005FFFFF,
        38'h10_00612345, 38'h01_00800000, 38'h01_0090000C, 38'h02_00A00030,
        38'h04_1FC00000, 38'h00_1F800000, 38'h00_00B00000, 38'h20_C0000000};

    assign sel = {dram_sel, parallel_sel, timer_sel, eprom_sel, serial_sel, user_sel};
    always #12.5 clk = ~clk;

    bdi_periph_model u_periph (.clk, .level_req, .strap_req, .counter_zero_output,
        .counter_one_output, .parallel_fifo_full_irq, .serial_ctrl_irq,
        .serial_gp_output_timer, .video_fifo_empty, .byte_order_strap);

    bdi_top u_dut (.clk, .rst, .addr, .addr_valid, .byte_order_strap, .emulation_mode,
        .route_custom, .route_sel0, .route_sel1, .route_sel2, .route_sel3,
        .counter_zero_output, .counter_one_output, .parallel_fifo_full_irq,
        .serial_ctrl_irq, .serial_gp_output_timer, .video_fifo_empty, .irq_input,
        .dram_sel, .parallel_sel, .timer_sel, .eprom_sel, .serial_sel, .user_sel, .dev_addr);

    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_sel(input logic [5:0] g, input logic [5:0] e); cmp({26'h0, g}, {26'h0, e}); endtask
    task automatic chk_irq(input logic [5:0] g, input logic [5:0] e); cmp({26'h0, g}, {26'h0, e}); endtask
    task automatic chk_addr(input logic [19:0] g, input logic [19:0] e); cmp({12'h0, g}, {12'h0, e}); endtask
    task automatic go(input int n); repeat (n) @(posedge clk); endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // strap settles through the partner and a three stage chain before the check
    task automatic t_reset_strap(input logic s);
        @(posedge clk);
        rst <= 1'b1;
        strap_req <= s;
        go(4);
        #1;
        chk_irq(irq_input, {5'h00, s});
        @(posedge clk);
        rst <= 1'b0;
        $display("test reset strap %0d done", s);
    endtask

    task automatic access(input logic [37:0] e);
        @(posedge clk);
        addr <= e[31:0];
        addr_valid <= 1'b1;
        @(posedge clk);
        addr_valid <= 1'b0;
        #1;
        chk_sel(sel, e[37:32]);
        chk_addr(dev_addr, e[19:0]);
    endtask

    task automatic t_decode(input logic emu);
        @(posedge clk);
        emulation_mode <= emu;
        go(3);
        if (emu) foreach (emu_tbl[i]) access(emu_tbl[i]);
        else foreach (std_tbl[i]) access(std_tbl[i]);
        $display("test decode map %0d done", emu);
    endtask

    // one source at a time; two edges of sync must not yet show it
    task automatic src_hit(input int s, input logic [5:0] e);
        @(posedge clk);
        level_req <= 6'h01 << s;
        go(3);
        #1;
        chk_irq(irq_input, 6'h00);
        go(1);
        #1;
        chk_irq(irq_input, e);
        @(posedge clk);
        level_req <= 6'h00;
        go(4);
    endtask

    task automatic t_irq(input logic emu, input logic cust, input logic [35:0] exp);
        @(posedge clk);
        emulation_mode <= emu;
        route_custom <= cust;
        go(4);
        for (int s = 0; s < 6; s++) src_hit(s, exp[6*s +: 6]);
        $display("test irq routing emu %0d custom %0d done", emu, cust);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            end_sim();
        end
    end

    initial begin
        t_reset_strap(1'b0);
        t_decode(1'b0);
        t_decode(1'b1);
        t_irq(1'b0, 1'b0, 36'h000808081);
        t_irq(1'b1, 1'b0, 36'h081808000);
        t_irq(1'b0, 1'b1, 36'h000001110);
        t_reset_strap(1'b1);
        end_sim();
    end
endmodule // bdi_top_tb_top
